//--- bench/testbench.sv
// Self-checking bench for the state register bank
`timescale 1ns/1ps
module testbench;
    import csm_pkg::*;
    localparam logic [15:0] MODEL_T = 16'hA5C3;   // Arbitrary value
    localparam logic [15:0] REV_T   = 16'h0042;   // Arbitrary value
    logic          clk_sys_i   = 1'b0;
    logic          reset_i     = 1'b1;
    logic          spr_wr_i    = 1'b0;
    logic          spr_rd_i    = 1'b0;
    csm_sel_type   spr_sel_i   = CSM_SEL_MSW;
    logic [31:0]   spr_wdata_i = 32'h0;
    logic [31:0]   spr_rdata_o;
    logic          spr_priv_err_o;
    logic          exc_take_i  = 1'b0;
    logic [31:0]   exc_msw_i   = 32'h0;
    logic [31:0]   eff_addr_i  = 32'h0;
    csm_ctrl_type  ctrl_o;
    csm_xlate_type xlate_o;
    logic [31:0]   msw_o;
    logic [31:0]   rd_val;
    int            err_count   = 0;
    int            checks      = 0;

    csm_regs #(.VBASE_RESET(1'b1), .MODEL_ID(MODEL_T), .REVISION_ID(REV_T))
    csm_regs_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .spr_wr_i(spr_wr_i), .spr_rd_i(spr_rd_i), .spr_sel_i(spr_sel_i),
        .spr_wdata_i(spr_wdata_i), .spr_rdata_o(spr_rdata_o),
        .spr_priv_err_o(spr_priv_err_o), .exc_take_i(exc_take_i),
        .exc_msw_i(exc_msw_i), .eff_addr_i(eff_addr_i), .ctrl_o(ctrl_o),
        .xlate_o(xlate_o), .msw_o(msw_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input csm_sel_type sel, input logic [31:0] d);
        @(posedge clk_sys_i);
        spr_wr_i    <= 1'b1;
        spr_sel_i   <= sel;
        spr_wdata_i <= d;
        @(posedge clk_sys_i);
        spr_wr_i    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input csm_sel_type sel);
        @(posedge clk_sys_i);
        spr_rd_i  <= 1'b1;
        spr_sel_i <= sel;
        @(posedge clk_sys_i);
        spr_rd_i  <= 1'b0;
        #1;
        rd_val = spr_rdata_o;
    endtask : rd

    task automatic take(input logic [31:0] d);
        @(posedge clk_sys_i);
        exc_take_i <= 1'b1;
        exc_msw_i  <= d;
        @(posedge clk_sys_i);
        exc_take_i <= 1'b0;
        #1;
    endtask : take

    task automatic settle(input logic [31:0] ea);
        eff_addr_i <= ea;
        @(posedge clk_sys_i);
        #1;
    endtask : settle

    function automatic logic [31:0] ctrl10(input csm_ctrl_type c);
        return {22'h0, c.ext_irq_take_ok, c.user_only, c.fp_dispatch_ok,
                c.mchk_take_ok, c.step_trace, c.branch_trace, c.fetch_xlate,
                c.data_xlate, c.recoverable, c.little_endian};
    endfunction : ctrl10

    task automatic t_bits();
        int pos [10] = '{MSW_EE_POS, MSW_PR_POS, MSW_FP_POS, MSW_ME_POS,
                         MSW_SE_POS, MSW_BT_POS, MSW_IR_POS, MSW_DR_POS,
                         MSW_RI_POS, MSW_LE_POS};
        check(msw_o, MSW_RESET_VAL, "reset word");
        check({20'h0, ctrl_o.vector_prefix}, 32'hFFF, "prefix");
        for (int i = 0; i < 10; i++) begin
            wr(CSM_SEL_MSW, 32'h1 << pos[i]);
            check(ctrl10(ctrl_o), 32'h200 >> i,
                  "ctrl");
        end
        wr(CSM_SEL_MSW, 32'hFFFF_FFFF);
        check(msw_o, MSW_DEFINED_MASK, "reserved");
        for (int m = 0; m < 4; m++) begin
            wr(CSM_SEL_MSW, (32'(m[1]) << MSW_FE0_POS) |
                            (32'(m[0]) << MSW_FE1_POS));
            check({30'h0, ctrl_o.fpx_mode}, 32'(m), "fp mode");
        end
        check({20'h0, ctrl_o.vector_prefix}, 32'h0, "prefix low");
        $display("Test state word done");
    endtask : t_bits

    task automatic t_vid();
        rd(CSM_SEL_VID);
        check(rd_val, {MODEL_T, REV_T}, "version");
        wr(CSM_SEL_VID, 32'h0);
        rd(CSM_SEL_VID);
        check(rd_val, {MODEL_T, REV_T}, "version kept");
        wr(CSM_SEL_MSW, 32'h1 << MSW_PR_POS);
        rd(CSM_SEL_VID);
        check(rd_val, 32'h0, "user read");
        check({31'h0, spr_priv_err_o}, 32'h1, "fault");
        @(posedge clk_sys_i);
        #1;
        check({31'h0, spr_priv_err_o}, 32'h0, "fault pulse");
        wr(CSM_SEL_MSW, 32'h1 << MSW_ILE_POS);
        take(32'h0);
        check(msw_o, 32'h1 << MSW_LE_POS, "trap order");
        take(32'h1 << MSW_LE_POS);
        check(msw_o, 32'h0, "trap order clear");
        $display("Test version and trap done");
    endtask : t_vid

    task automatic t_bmap();
        wr(CSM_SEL_BMU, {15'h1230, 4'h0, 11'h00F, 2'h2});
        wr(CSM_SEL_BML, {15'h4560, 10'h0, 4'hA, 1'h0, 2'h2});
        rd(CSM_SEL_BMU);
        check(rd_val, {15'h1230, 4'h0, 11'h00F, 2'h2}, "upper");
        settle({15'h1235, 17'h0ABCD});
        check({31'h0, xlate_o.hit}, 32'h1, "hit");
        check(xlate_o.phys_addr, {15'h4565, 17'h0ABCD}, "phys");
        check({28'h0, xlate_o.cache_attr}, 32'hA, "attr");
        check({30'h0, xlate_o.protect}, 32'h2, "protect");
        settle({15'h1275, 17'h0ABCD});
        check({31'h0, xlate_o.hit}, 32'h0, "miss");
        settle({15'h1235, 17'h0ABCD});
        wr(CSM_SEL_MSW, 32'h1 << MSW_PR_POS);
        check({31'h0, xlate_o.hit}, 32'h0, "user miss");
        wr(CSM_SEL_BMU, {15'h1230, 4'h0, 11'h00F, 2'h3});
        check({31'h0, xlate_o.hit}, 32'h1, "user hit");
        $display("Test block map done");
    endtask : t_bmap

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (2000) @(posedge clk_sys_i);
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        t_bits();
        t_vid();
        t_bmap();
        tally_and_finish();
    end
endmodule : testbench

//--- pkg/csm_pkg.sv
// Package: field layout, reset values and carriers for the state register bank
package csm_pkg;

    // Big-endian bit numbers (bit 0 = msb) mapped to vector index 31-n
    localparam int MSW_EE_POS   = 31 - 16;
    localparam int MSW_PR_POS   = 31 - 17;
    localparam int MSW_FP_POS   = 31 - 18;
    localparam int MSW_ME_POS   = 31 - 19;
    localparam int MSW_FE0_POS  = 31 - 20;
    localparam int MSW_SE_POS   = 31 - 21;
    localparam int MSW_BT_POS   = 31 - 22;
    localparam int MSW_FE1_POS  = 31 - 23;
    localparam int MSW_IP_POS   = 31 - 25;
    localparam int MSW_IR_POS   = 31 - 26;
    localparam int MSW_DR_POS   = 31 - 27;
    localparam int MSW_RI_POS   = 31 - 30;
    localparam int MSW_LE_POS   = 31 - 31;
    localparam int MSW_ILE_POS  = 31 - 15;
    localparam int MSW_POW_POS  = 31 - 13;

    // Defined bits are all zero at power-up except the vector base
    localparam logic [31:0] MSW_RESET_VAL    = 32'h0000_0040;
    // Bits held in flops; the rest read zero
    localparam logic [31:0] MSW_DEFINED_MASK = 32'h0005_FF73;

    // Block map field positions (32-bit form)
    localparam int BMU_BLOCK_EFF_INDEX_LSB = 31 - 14;
    localparam int BMU_BL_LSB   = 31 - 29;
    localparam int BMU_VS_POS   = 31 - 30;
    localparam int BMU_VP_POS   = 31 - 31;
    localparam int BML_BLOCK_PHYS_NUMBER_LSB = 31 - 14;
    localparam int BML_CACHE_ATTR_BITS_LSB = 31 - 28;
    localparam int BML_PP_LSB   = 31 - 31;

    localparam logic [31:0] BMU_WR_MASK = 32'hFFFE_1FFF;
    localparam logic [31:0] BML_WR_MASK = 32'hFFFE_007B;
    localparam logic [31:0] BMAP_RESET_VAL = 32'h0000_0000;

    // Arbitrary neutral identity values
    localparam logic [15:0] VID_MODEL_DEF = 16'h0001;
    localparam logic [15:0] VID_REV_DEF   = 16'h0001;

    // Floating-point exception modes
    typedef enum logic [1:0] {
        CSM_FPX_OFF     = 2'h0,
        CSM_FPX_IMP_NR  = 2'h1,
        CSM_FPX_IMP_REC = 2'h2,
        CSM_FPX_PRECISE = 2'h3
    } csm_fpx_mode_type;

    typedef enum logic [1:0] {
        CSM_SEL_MSW = 2'h0,
        CSM_SEL_VID = 2'h1,
        CSM_SEL_BMU = 2'h2,
        CSM_SEL_BML = 2'h3
    } csm_sel_type;

    // Decoded core controls
    typedef struct packed {
        logic             user_only;
        logic             fp_dispatch_ok;
        logic             mchk_take_ok;
        logic             ext_irq_take_ok;
        logic             step_trace;
        logic             branch_trace;
        csm_fpx_mode_type fpx_mode;
        logic             fetch_xlate;
        logic             data_xlate;
        logic             recoverable;
        logic             little_endian;
        logic [11:0]      vector_prefix;
    } csm_ctrl_type;

    // Block translation result
    typedef struct packed {
        logic        hit;
        logic [31:0] phys_addr;
        logic [3:0]  cache_attr;
        logic [1:0]  protect;
    } csm_xlate_type;

endpackage : csm_pkg

//--- rtl/csm_regs.sv
// Machine state word, version id and block map register bank
`timescale 1ns/1ps

// How it works
// - user_state set limits core to user instructions; clear allows both.
// - float_unit_on clear blocks all floating-point dispatch, loads, stores.
// - Machine checks are taken only while machine_check_on is one.
// - step_trace_on raises single-step trace after next good instruction.
// - branch_trace_on raises branch trace after any completed branch.
// - vector_base_high picks vector base 0x000n_nnnn or 0xFFFn_nnnn.
// - fetch_translate_on and data_translate_on enable their translations.
// - recoverable_flag reports one when reset or machine check is recoverable.
// - byte_order_select set means little-endian, clear means big-endian.
// - float_exc_mode_a and _b pick off, imprecise two kinds, or precise.
// - Defined state bits reset to zero except vector_base_high.
// - vector_base_high resets to one by default, zero allowed by parameter.
// - Reserved state bits have no guaranteed reset value.
// - version_id_reg is read-only, supervisor-readable, writes ignored.
// - version_id_reg holds model in bits 0-15, revision in 16-31.
// - Effective index compared with high effective address bits for hit.
// - region_size_mask low ones encode 128 Kbytes up to 256 Mbytes.
// - Match needs kernel_valid in supervisor, user_valid in user state.
// - block_phys_number with size mask supplies high physical address bits.
// - cache_attr_bits: write-through, inhibit, coherence, guarded, in order.
// - access_protect holds the protection applied to hitting accesses.
// - ext_irq_on clear postpones external and decrementer interrupts.
// - On any exception handler_byte_order is copied into byte_order_select.
module csm_regs #(
    parameter logic        VBASE_RESET = 1'b1,         // Vector base at reset
    parameter logic [15:0] MODEL_ID    = 16'h0001,     // Arbitrary value
    parameter logic [15:0] REVISION_ID = 16'h0001      // Arbitrary value
) (
    input  wire logic                 clk_sys_i,       // Core clock
    input  wire logic                 reset_i,         // Sync reset, high
    input  wire logic                 spr_wr_i,        // Move-to strobe
    input  wire logic                 spr_rd_i,        // Move-from strobe
    input  wire csm_pkg::csm_sel_type spr_sel_i,       // Register select
    input  wire logic [31:0]          spr_wdata_i,     // Write data
    output logic [31:0]               spr_rdata_o,     // Read data
    output logic                      spr_priv_err_o,  // Privileged read fault
    input  wire logic                 exc_take_i,      // Exception taken
    input  wire logic [31:0]          exc_msw_i,       // State loaded on trap
    input  wire logic [31:0]          eff_addr_i,      // Effective address
    output csm_pkg::csm_ctrl_type     ctrl_o,          // Decoded controls
    output csm_pkg::csm_xlate_type    xlate_o,         // Block translation
    output logic [31:0]               msw_o            // Current state word
);
    import csm_pkg::*;

    logic [31:0] msw_reg;
    logic [31:0] msw_next;
    logic [31:0] bmu_reg;
    logic [31:0] bml_reg;
    logic [31:0] vid_word;
    logic [31:0] rdata_reg;
    logic        priv_err_reg;

    logic [14:0] block_eff_index;
    logic [10:0] bl_mask;
    logic [14:0] ea_hi;
    logic [14:0] block_phys_number;
    logic        valid_ok;

    assign vid_word = {MODEL_ID, REVISION_ID};

    // State word: trap load wins over a software move in the same cycle
    always_comb begin
        msw_next = msw_reg;
        if (exc_take_i) begin
            msw_next = exc_msw_i & MSW_DEFINED_MASK;
            msw_next[MSW_LE_POS] = msw_reg[MSW_ILE_POS];
        end else if (spr_wr_i && spr_sel_i == CSM_SEL_MSW) begin
            msw_next = spr_wdata_i & MSW_DEFINED_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            msw_reg <= MSW_RESET_VAL;
            msw_reg[MSW_IP_POS] <= VBASE_RESET;
        end else begin
            msw_reg <= msw_next;
        end
    end

    // Block map pair; reserved fields never stored
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            bmu_reg <= BMAP_RESET_VAL;
            bml_reg <= BMAP_RESET_VAL;
        end else if (spr_wr_i) begin
            if (spr_sel_i == CSM_SEL_BMU)
                bmu_reg <= spr_wdata_i & BMU_WR_MASK;
            if (spr_sel_i == CSM_SEL_BML)
                bml_reg <= spr_wdata_i & BML_WR_MASK;
        end
    end

    // Reads registered; id read from user state faults and returns zero
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rdata_reg    <= 32'h0000_0000;
            priv_err_reg <= 1'b0;
        end else begin
            priv_err_reg <= 1'b0;
            if (spr_rd_i) begin
                case (spr_sel_i)
                    CSM_SEL_MSW: rdata_reg <= msw_reg;
                    CSM_SEL_VID: begin
                        if (msw_reg[MSW_PR_POS]) begin
                            rdata_reg    <= 32'h0000_0000;
                            priv_err_reg <= 1'b1;
                        end else begin
                            rdata_reg <= vid_word;
                        end
                    end
                    CSM_SEL_BMU: rdata_reg <= bmu_reg;
                    CSM_SEL_BML: rdata_reg <= bml_reg;
                    default:     rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign spr_rdata_o    = rdata_reg;
    assign spr_priv_err_o = priv_err_reg;
    assign msw_o          = msw_reg;

    // Decoded controls for the core
    always_comb begin
        ctrl_o.user_only       = msw_reg[MSW_PR_POS];
        ctrl_o.fp_dispatch_ok  = msw_reg[MSW_FP_POS];
        ctrl_o.mchk_take_ok    = msw_reg[MSW_ME_POS];
        ctrl_o.ext_irq_take_ok = msw_reg[MSW_EE_POS];
        ctrl_o.step_trace      = msw_reg[MSW_SE_POS];
        ctrl_o.branch_trace    = msw_reg[MSW_BT_POS];
        ctrl_o.fpx_mode        = csm_fpx_mode_type'(
            {msw_reg[MSW_FE0_POS], msw_reg[MSW_FE1_POS]});
        ctrl_o.fetch_xlate     = msw_reg[MSW_IR_POS];
        ctrl_o.data_xlate      = msw_reg[MSW_DR_POS];
        ctrl_o.recoverable     = msw_reg[MSW_RI_POS];
        ctrl_o.little_endian   = msw_reg[MSW_LE_POS];
        ctrl_o.vector_prefix   = msw_reg[MSW_IP_POS] ? 12'hFFF
                                                     : 12'h000;
    end

    // Block translation: masked index compare, privilege valid
    assign block_eff_index     = bmu_reg[BMU_BLOCK_EFF_INDEX_LSB +: 15];
    assign bl_mask  = bmu_reg[BMU_BL_LSB +: 11];
    assign ea_hi    = eff_addr_i[31:17];
    assign block_phys_number     = bml_reg[BML_BLOCK_PHYS_NUMBER_LSB +: 15];
    assign valid_ok = msw_reg[MSW_PR_POS] ? bmu_reg[BMU_VP_POS]
                                          : bmu_reg[BMU_VS_POS];

    always_comb begin
        logic [14:0] m;
        m = {4'h0, bl_mask};
        xlate_o.hit = valid_ok &&
            ((block_eff_index & ~m) == (ea_hi & ~m));
        xlate_o.phys_addr = {(block_phys_number & ~m) | (ea_hi & m),
                             eff_addr_i[16:0]};
        xlate_o.cache_attr = bml_reg[BML_CACHE_ATTR_BITS_LSB +: 4];
        xlate_o.protect    = bml_reg[BML_PP_LSB +: 2];
    end

    // Checks; one clock domain, so one default clocking and disable
    default clocking cb_core @(posedge clk_sys_i);
    endclocking

    default disable iff (reset_i);

    sequence s_trap_in;
        exc_take_i;
    endsequence

    sequence s_msw_move;
        spr_wr_i && spr_sel_i == CSM_SEL_MSW && !exc_take_i;
    endsequence

    sequence s_vid_read_sup;
        spr_rd_i && spr_sel_i == CSM_SEL_VID && !msw_reg[MSW_PR_POS];
    endsequence

    sequence s_vid_read_user;
        spr_rd_i && spr_sel_i == CSM_SEL_VID && msw_reg[MSW_PR_POS];
    endsequence

    sequence s_vid_move;
        spr_wr_i && spr_sel_i == CSM_SEL_VID && !exc_take_i;
    endsequence

    sequence s_bmu_move;
        spr_wr_i && spr_sel_i == CSM_SEL_BMU;
    endsequence

    sequence s_bml_move;
        spr_wr_i && spr_sel_i == CSM_SEL_BML;
    endsequence

    sequence s_read_idle;
        !spr_rd_i;
    endsequence

    // Reset checks must stay live while reset is high
    a_reset_state: assert property (disable iff (1'b0)
        reset_i |=> (msw_reg & ~(32'h0000_0001 << MSW_IP_POS)) == 32'h0)
        else $error("state word not cleared by reset");

    a_reset_vbase: assert property (disable iff (1'b0)
        reset_i |=> msw_reg[MSW_IP_POS] == VBASE_RESET)
        else $error("vector base reset value wrong");

    a_reset_maps: assert property (disable iff (1'b0)
        reset_i |=> bmu_reg == BMAP_RESET_VAL && bml_reg == BMAP_RESET_VAL)
        else $error("block map not cleared by reset");

    a_reserved_zero: assert property (
        (msw_reg & ~MSW_DEFINED_MASK) == 32'h0)
        else $error("reserved state bit stored");

    a_msw_write: assert property (
        s_msw_move |=> msw_reg == ($past(spr_wdata_i) & MSW_DEFINED_MASK))
        else $error("state word write lost");

    a_trap_endian: assert property (
        s_trap_in |=> msw_reg[MSW_LE_POS] == $past(msw_reg[MSW_ILE_POS]))
        else $error("endian not copied on trap");

    // Trap load must win over a move landing in the same cycle
    a_trap_load: assert property (
        s_trap_in |=> (msw_reg & ~(32'h0000_0001 << MSW_LE_POS)) ==
            ($past(exc_msw_i) & MSW_DEFINED_MASK
             & ~(32'h0000_0001 << MSW_LE_POS)))
        else $error("trap state not loaded");

    a_user_gate: assert property (
        ctrl_o.user_only == msw_reg[MSW_PR_POS])
        else $error("user state gate wrong");

    a_fp_block: assert property (
        ctrl_o.fp_dispatch_ok == msw_reg[MSW_FP_POS])
        else $error("float dispatch gate wrong");

    a_mchk_gate: assert property (
        ctrl_o.mchk_take_ok == msw_reg[MSW_ME_POS])
        else $error("machine check gate wrong");

    a_step_gate: assert property (
        ctrl_o.step_trace == msw_reg[MSW_SE_POS])
        else $error("step trace enable wrong");

    a_branch_gate: assert property (
        ctrl_o.branch_trace == msw_reg[MSW_BT_POS])
        else $error("branch trace enable wrong");

    a_vector_base: assert property (
        ctrl_o.vector_prefix == (msw_reg[MSW_IP_POS] ? 12'hFFF : 12'h000))
        else $error("vector prefix wrong");

    a_fetch_gate: assert property (
        ctrl_o.fetch_xlate == msw_reg[MSW_IR_POS])
        else $error("fetch translation enable wrong");

    a_data_gate: assert property (
        ctrl_o.data_xlate == msw_reg[MSW_DR_POS])
        else $error("data translation enable wrong");

    a_recover_flag: assert property (
        ctrl_o.recoverable == msw_reg[MSW_RI_POS])
        else $error("recoverable flag wrong");

    a_endian_mode: assert property (
        ctrl_o.little_endian == msw_reg[MSW_LE_POS])
        else $error("byte order wrong");

    a_fpx_mode: assert property (
        ctrl_o.fpx_mode == {msw_reg[MSW_FE0_POS], msw_reg[MSW_FE1_POS]})
        else $error("float exception mode wrong");

    a_irq_gate: assert property (
        ctrl_o.ext_irq_take_ok == msw_reg[MSW_EE_POS])
        else $error("external interrupt gate wrong");

    a_vid_ro: assert property (
        s_vid_read_sup |=> spr_rdata_o == {MODEL_ID, REVISION_ID})
        else $error("version id read wrong");

    a_vid_fields: assert property (
        s_vid_read_sup |=> spr_rdata_o[31:16] == MODEL_ID &&
                           spr_rdata_o[15:0] == REVISION_ID)
        else $error("version id fields swapped");

    a_vid_user: assert property (
        s_vid_read_user |=> spr_priv_err_o && spr_rdata_o == 32'h0)
        else $error("user read of version id not refused");

    a_priv_pulse: assert property (
        spr_priv_err_o |->
            $past(spr_rd_i && spr_sel_i == CSM_SEL_VID && msw_reg[MSW_PR_POS]))
        else $error("fault without user id read");

    a_vid_no_write: assert property (
        s_vid_move |=> $stable(msw_reg) && $stable(bmu_reg) && $stable(bml_reg))
        else $error("version id write changed state");

    a_rdata_hold: assert property (
        s_read_idle |=> $stable(spr_rdata_o))
        else $error("read data moved without a read");

    a_bmu_mask: assert property (
        (bmu_reg & ~BMU_WR_MASK) == 32'h0)
        else $error("upper map reserved bit stored");

    a_bml_mask: assert property (
        (bml_reg & ~BML_WR_MASK) == 32'h0)
        else $error("lower map reserved bit stored");

    a_bmu_write: assert property (
        s_bmu_move |=> bmu_reg == ($past(spr_wdata_i) & BMU_WR_MASK))
        else $error("upper map write lost");

    a_bml_write: assert property (
        s_bml_move |=> bml_reg == ($past(spr_wdata_i) & BML_WR_MASK))
        else $error("lower map write lost");

    a_hit_priv: assert property (
        xlate_o.hit |-> (msw_reg[MSW_PR_POS] ? bmu_reg[BMU_VP_POS]
                                             : bmu_reg[BMU_VS_POS]))
        else $error("hit without valid bit");

    a_hit_match: assert property (
        xlate_o.hit |-> ((block_eff_index ^ ea_hi) & ~{4'h0, bl_mask}) == 15'h0000)
        else $error("hit on differing index");

    a_match_hit: assert property (
        valid_ok && ((block_eff_index ^ ea_hi) & ~{4'h0, bl_mask}) == 15'h0000
        |-> xlate_o.hit)
        else $error("matching index missed");

    a_phys_high: assert property (
        (xlate_o.phys_addr[31:17] & ~{4'h0, bl_mask}) ==
        (block_phys_number & ~{4'h0, bl_mask}))
        else $error("block number not applied");

    a_phys_pass: assert property (
        (xlate_o.phys_addr[31:17] & {4'h0, bl_mask}) ==
        (ea_hi & {4'h0, bl_mask}))
        else $error("masked address bits not passed");

    a_phys_low: assert property (
        xlate_o.phys_addr[16:0] == eff_addr_i[16:0])
        else $error("block offset altered");

    a_attr_bits: assert property (
        xlate_o.cache_attr == bml_reg[BML_CACHE_ATTR_BITS_LSB +: 4])
        else $error("cache attributes wrong");

    a_protect: assert property (
        xlate_o.protect == bml_reg[BML_PP_LSB +: 2])
        else $error("protection bits wrong");

endmodule : csm_regs
